// ==== core/ccr_config_regs.sv ====
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module ccr_config_regs
   import ccr_pkg::*;
#(
   parameter int WD_UNIT = ccr_pkg::WD_UNIT_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic dualLink,
   input wire logic partnerProtected,
   input wire logic syncClkEn,
   input wire logic pixel_valid,
   input wire logic line_sync,
   input wire logic frame_sync,
   input wire logic [23:0] colourIn,
   output logic [23:0] colourOut,
   output logic pixelValidOut,
   output logic lineSyncOut,
   output logic frameSyncOut,
   output logic back_check_gen_en,
   output logic undriven_pull_dir,
   output logic [5:0] sdaHoldNs,
   output logic [6:0] glitchMaxNs,
   input wire logic linkLocked,
   input wire logic twiStart,
   input wire logic twiIsWrite,
   input wire logic twiAddrMatch,
   input wire logic twiDone,
   output logic twiForward,
   output logic twiSelfAck,
   output logic twiAbort,
   output logic twiBusy
);
   import ccr_pkg::*;

   typedef enum logic [1:0] {WD_IDLE, WD_RUN} ccr_wd_t;

   logic [7:0] gen1;
   logic [7:0] wdog;
   logic [7:0] twi1;
   logic [2:0] irqStat;
   logic [2:0] irqMask;
   ccr_wd_t wdState;
   logic [31:0] unitCnt;
   logic [6:0] unitsLeft;
   logic [2:0] runLen [3];
   logic [2:0] syncOut;
   logic [23:0] colourQ;
   logic [2:0] evt;
   logic wrEn;
   logic rdEn;
   logic known;
   logic [2:0] syncIn;
   logic filterOn;
   logic passOn;
   logic sackOn;
   logic gateOn;
   logic fwdAll;
   logic wdOff;
   logic [6:0] timeoutField;
   logic [2:0] holdField;
   logic [3:0] glitchField;
   logic unitEnd;
   logic expire;

   function automatic logic sel(input logic [11:0] a, input logic [11:0] ofs);
      return a == ofs;
   endfunction

   // every offset that answers without a slave error
   function automatic logic mapped(input logic [11:0] a);
      return sel(a, GEN1_OFS) || sel(a, WDOG_OFS) || sel(a, TWI1_OFS)
         || sel(a, IRQ_STAT_OFS) || sel(a, IRQ_MASK_OFS) || sel(a, STAT_OFS);
   endfunction

   // read mux: unmapped offsets read as zero, data sits in the low byte
   function automatic logic [31:0] readWord(input logic [11:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (sel(a, GEN1_OFS)) begin
         w[7:0] = gen1;
      end
      if (sel(a, WDOG_OFS)) begin
         w[7:0] = wdog;
      end
      if (sel(a, TWI1_OFS)) begin
         w[7:0] = twi1;
      end
      if (sel(a, IRQ_STAT_OFS)) begin
         w[2:0] = irqStat;
      end
      if (sel(a, IRQ_MASK_OFS)) begin
         w[2:0] = irqMask;
      end
      if (sel(a, STAT_OFS)) begin
         w[7:0] = {unitsLeft, twiBusy};
      end
      return w;
   endfunction

   // zero-wait-state slave
   assign pready = 1'b1;
   assign wrEn = clkEn && psel && penable && pwrite;
   assign rdEn = clkEn && psel && penable && !pwrite;
   assign known = mapped(paddr);
   assign pslverr = psel && penable && !known;

   // general setup: reserved bits 7 and 0 never store a one
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         gen1 <= GEN1_RST;
      end else if (wrEn && sel(paddr, GEN1_OFS)) begin
         gen1 <= pwdata[7:0] & GEN1_WMASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wdog <= WDOG_RST;
      end else if (wrEn && sel(paddr, WDOG_OFS)) begin
         wdog <= pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         twi1 <= TWI1_RST;
      end else if (wrEn && sel(paddr, TWI1_OFS)) begin
         twi1 <= pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irqMask <= 3'h0;
      end else if (wrEn && sel(paddr, IRQ_MASK_OFS)) begin
         irqMask <= pwdata[2:0];
      end
   end

   // read data is registered at the access edge and holds until the next read
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (rdEn) begin
         prdata <= readWord(paddr);
      end
   end

   // sticky status: a new event wins over a write-one clear
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         irqStat <= 3'h0;
      end else if (clkEn) begin
         if (wrEn && sel(paddr, IRQ_STAT_OFS)) begin
            irqStat <= (irqStat & ~pwdata[2:0]) | evt;
         end else begin
            irqStat <= irqStat | evt;
         end
      end
   end
   assign irq = |(irqStat & irqMask);

   assign back_check_gen_en = gen1[CHK_BIT]; // RULE1
   assign undriven_pull_dir = gen1[PULL_BIT]; // RULE2
   // field views of the setup registers
   assign filterOn = gen1[FILT_BIT];
   assign passOn = gen1[PASS_BIT];
   assign sackOn = gen1[SACK_BIT];
   assign gateOn = gen1[GATE_BIT];
   assign fwdAll = twi1[FWD_ALL_BIT];
   assign wdOff = wdog[WD_OFF_BIT];
   assign timeoutField = wdog[7:1];
   assign holdField = twi1[6:4];
   assign glitchField = twi1[3:0];

   // hold is reported in 10 ns units, so the largest field needs six bits
   assign sdaHoldNs = 6'(holdField * HOLD_STEP_NS / 10); // RULE14
   assign glitchMaxNs = 7'(glitchField * GLITCH_STEP_NS); // RULE15

   // sync filter, sampled on pixel-clock enable strobes
   assign syncIn = {frame_sync, line_sync, pixel_valid};
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         logic [2:0] minLen;
         assign minLen = (gi == 1 && dualLink) ? 3'(SYNC_MIN_DUAL) : 3'(SYNC_MIN_SINGLE); // RULE4
         always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
               runLen[gi] <= 3'h0;
               syncOut[gi] <= 1'b0;
            end else if (clkEn && syncClkEn) begin
               if (!filterOn) begin
                  syncOut[gi] <= syncIn[gi];
                  runLen[gi] <= 3'h0;
               end else if (syncIn[gi] == syncOut[gi]) begin
                  runLen[gi] <= 3'h0;
               end else if (runLen[gi] + 3'h1 >= minLen) begin
                  syncOut[gi] <= syncIn[gi]; // RULE3
                  runLen[gi] <= 3'h0;
               end else begin
                  runLen[gi] <= runLen[gi] + 3'h1;
               end
            end
         end
      end
   endgenerate
   assign pixelValidOut = syncOut[0];
   assign lineSyncOut = syncOut[1];
   assign frameSyncOut = syncOut[2];

   // colour delayed one strobe, aligning with filtered valid only while the filter is bypassed
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         colourQ <= 24'h00_0000;
      end else if (clkEn && syncClkEn) begin
         colourQ <= colourIn;
      end
   end
   assign colourOut = (partnerProtected || gateOn) && !pixelValidOut ?
      24'h00_0000 : colourQ; // RULE7 RULE8

   // two-wire pass-through decisions
   assign twiForward = twiStart && (fwdAll || (passOn && twiAddrMatch)); // RULE5 RULE13
   assign twiSelfAck = twiStart && twiIsWrite && sackOn; // RULE6

   // control-link watchdog: one unit is WD_UNIT clocks; a zero field expires after one unit
   assign unitEnd = unitCnt == 32'(WD_UNIT - 1);
   assign expire = wdState == WD_RUN && !twiDone && !wdOff && unitEnd // RULE12
      && unitsLeft <= 7'h01;

   // state: timed from a forwarded start until done or expiry
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wdState <= WD_IDLE;
      end else if (clkEn) begin
         unique case (wdState)
            WD_IDLE: begin
               if (twiForward) begin
                  wdState <= WD_RUN; // RULE16
               end
            end
            WD_RUN: begin
               if (twiDone || expire) begin
                  wdState <= WD_IDLE; // RULE16
               end
            end
            default: begin
               wdState <= WD_IDLE;
            end
         endcase
      end
   end

   // unit prescaler, held at zero while idle so each transaction starts afresh
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         unitCnt <= 32'h0000_0000;
      end else if (clkEn) begin
         if (wdState == WD_IDLE) begin
            unitCnt <= 32'h0000_0000;
         end else if (!twiDone && !wdOff) begin // RULE12
            if (unitEnd) begin
               unitCnt <= 32'h0000_0000;
            end else begin
               unitCnt <= unitCnt + 32'h1;
            end
         end
      end
   end

   // units still to run, loaded from the field at the start
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         unitsLeft <= 7'h00;
      end else if (clkEn) begin
         if (wdState == WD_IDLE) begin
            if (twiForward) begin
               unitsLeft <= timeoutField; // RULE9
            end
         end else if (expire) begin
            unitsLeft <= 7'h00;
         end else if (!twiDone && !wdOff && unitEnd) begin
            unitsLeft <= unitsLeft - 7'h01;
         end
      end
   end

   // one-cycle termination pulse
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         twiAbort <= 1'b0;
      end else if (clkEn) begin
         twiAbort <= expire; // RULE10
      end
   end
   assign twiBusy = wdState == WD_RUN;

   assign evt = {twiStart && !twiForward && !twiSelfAck,
      wdState == WD_RUN && twiDone && clkEn, twiAbort && clkEn};
endmodule

// ==== core/ccr_pkg.sv ====
// How it works
// RULE1 - check code appended when enable bit set
// RULE2 - pull bit: one pulls down, zero up
// RULE3 - filter rejects sync pulses under two clocks
// RULE4 - line sync needs four clocks in dual
// RULE5 - matched addresses forwarded when pass bit set
// RULE6 - self-acknowledge writes regardless of link lock
// RULE7 - protected partner always gates colour by valid
// RULE8 - unprotected partner gates only when bit set
// RULE9 - timeout field counts in two millisecond units
// RULE10 - unfinished transaction terminated at timeout
// RULE11 - software avoids zero timeout value
// RULE12 - disable bit stops the watchdog
// RULE13 - forward-all passes every transaction
// RULE14 - hold field in fifty nanosecond steps
// RULE15 - glitch filter in five nanosecond steps
// RULE16 - watchdog restarts per transaction, stops at end
package ccr_pkg;
   localparam logic [11:0] GEN1_OFS = 12'h00C;
   localparam logic [11:0] WDOG_OFS = 12'h010;
   localparam logic [11:0] TWI1_OFS = 12'h014;
   localparam logic [11:0] IRQ_STAT_OFS = 12'h020;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h024;
   localparam logic [11:0] STAT_OFS = 12'h028;
   localparam logic [7:0] GEN1_RST = 8'h70;
   localparam logic [7:0] WDOG_RST = 8'hFE;
   localparam logic [7:0] TWI1_RST = 8'h1E;
   localparam logic [7:0] GEN1_WMASK = 8'h7E;
   localparam int CHK_BIT = 6;
   localparam int PULL_BIT = 5;
   localparam int FILT_BIT = 4;
   localparam int PASS_BIT = 3;
   localparam int SACK_BIT = 2;
   localparam int GATE_BIT = 1;
   localparam int WD_OFF_BIT = 0;
   localparam int FWD_ALL_BIT = 7;
   localparam int CLK_MHZ = 50;
   localparam int CLK_NS = 20;
   localparam int WD_UNIT_MS = 2;
   localparam int WD_UNIT_CYC = WD_UNIT_MS * 1000 * CLK_MHZ;
   localparam int HOLD_STEP_NS = 50;
   localparam int GLITCH_STEP_NS = 5;
   localparam int SYNC_MIN_SINGLE = 2;
   localparam int SYNC_MIN_DUAL = 4;
   localparam int IRQ_TIMEOUT = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_REJECT = 2;
endpackage

// ==== dv/ccr_config_regs_props.sv ====
`timescale 1ns/1ps
module ccr_config_regs_props (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pslverr,
   input wire logic back_check_gen_en,
   input wire logic undriven_pull_dir,
   input wire logic [5:0] sdaHoldNs,
   input wire logic [6:0] glitchMaxNs,
   input wire logic twiStart,
   input wire logic twiIsWrite,
   input wire logic twiDone,
   input wire logic twiForward,
   input wire logic twiSelfAck,
   input wire logic twiAbort,
   input wire logic twiBusy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_rst_bits; $past(sys_rst) |-> back_check_gen_en && undriven_pull_dir; endproperty
   a_rst_bits: assert property (p_rst_bits) else $error("reset bits wrong");
   property p_rst_fld; $past(sys_rst) |-> sdaHoldNs == 6'd5 && glitchMaxNs == 7'd70; endproperty
   a_rst_fld: assert property (p_rst_fld) else $error("reset fields wrong");
   property p_sack; twiSelfAck |-> twiStart && twiIsWrite; endproperty
   a_sack: assert property (p_sack) else $error("stray self ack");
   property p_fwd; twiForward |-> twiStart; endproperty
   a_fwd: assert property (p_fwd) else $error("stray forward");
   property p_abort; twiAbort |=> !twiAbort; endproperty
   a_abort: assert property (p_abort) else $error("abort too long");
   property p_done; twiDone && twiBusy && !twiStart |=> !twiBusy && !twiAbort; endproperty
   a_done: assert property (p_done) else $error("watchdog ran on");
   property p_busy; $rose(twiBusy) |-> $past(twiForward); endproperty
   a_busy: assert property (p_busy) else $error("busy without start");
   property p_err; pslverr |-> psel && penable; endproperty
   a_err: assert property (p_err) else $error("error outside access");
   c_abort: cover property (twiAbort);
   c_sack: cover property (twiSelfAck);
   c_err: cover property (pslverr);
endmodule
bind ccr_config_regs ccr_config_regs_props props_u (.sys_clk, .sys_rst, .psel, .penable,
   .pslverr, .back_check_gen_en, .undriven_pull_dir, .sdaHoldNs, .glitchMaxNs, .twiStart,
   .twiIsWrite, .twiDone, .twiForward, .twiSelfAck, .twiAbort, .twiBusy);

// ==== dv/ccr_serializer_model.sv ====
`timescale 1ns/1ps
module ccr_serializer_model (
   input wire logic sys_clk,
   input wire logic twiForward,
   input wire logic stall,
   output logic twiDone
);
   int left = -1;
   initial twiDone = 1'b0;
   // completes a forwarded transaction a few cycles later, never while stalled
   always @(posedge sys_clk) begin
      twiDone <= 1'b0;
      if (twiForward) begin
         left <= 4;
      end else if (left > 0) begin
         left <= left - 1;
      end else if (left == 0) begin
         left <= -1;
         twiDone <= !stall;
      end
   end
endmodule

// ==== dv/tb_control_channel_config_regs.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_control_channel_config_regs;
   import ccr_pkg::*;
   logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, stall = 0, e;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, irq, back_check_gen_en, undriven_pull_dir, pixelValidOut;
   logic partnerProtected = 0, pixel_valid = 0, syncClkEn = 1, twiAbort, twiBusy;
   logic dualLink = 0, line_sync = 0, lineSyncOut;
   logic twiStart = 0, twiIsWrite = 0, twiAddrMatch = 0, twiDone, twiForward, twiSelfAck;
   logic [23:0] colourIn = 24'hAB_CDEF, colourOut;
   logic [5:0] sdaHoldNs;
   logic [6:0] glitchMaxNs;
   int fails = 0, comparisons = 0, cyc = 0, n;
   ccr_config_regs #(.WD_UNIT(10)) dut_u (.sys_clk, .sys_rst, .clkEn(1'b1), .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .dualLink,
      .partnerProtected, .syncClkEn, .pixel_valid, .line_sync, .frame_sync(1'b0),
      .colourIn, .colourOut, .pixelValidOut, .lineSyncOut, .frameSyncOut(),
      .back_check_gen_en, .undriven_pull_dir, .sdaHoldNs, .glitchMaxNs, .linkLocked(1'b1),
      .twiStart, .twiIsWrite, .twiAddrMatch, .twiDone, .twiForward, .twiSelfAck, .twiAbort,
      .twiBusy);
   ccr_serializer_model peer_u (.sys_clk, .twiForward, .stall, .twiDone);
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         end_of_test();
      end
   end
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d, x, input logic xe);
      @(posedge sys_clk) begin psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; end
      @(posedge sys_clk) penable <= 1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge sys_clk);
      if (!w) `CHK(prdata, x)
      `CHK(e, xe)
   endtask
   task st(input logic w, m, ef, es);
      @(posedge sys_clk) begin twiIsWrite <= w; twiAddrMatch <= m; twiStart <= 1; end
      @(negedge sys_clk) begin `CHK(twiForward, ef) `CHK(twiSelfAck, es) end
      @(posedge sys_clk) twiStart <= 0;
   endtask
   task wab;
      n = 0;
      while (twiAbort !== 1'b1 && n < 100) begin @(negedge sys_clk); n++; end
   endtask
   task t_reset;
      bus(0, GEN1_OFS, 0, 32'h0000_0070, 0);
      bus(0, WDOG_OFS, 0, 32'h0000_00FE, 0);
      bus(0, TWI1_OFS, 0, 32'h0000_001E, 0);
      bus(0, 12'h03C, 0, 0, 1);
      bus(1, GEN1_OFS, 32'h0000_00FF, 0, 0);
      bus(0, GEN1_OFS, 0, 32'h0000_007E, 0);
      bus(1, GEN1_OFS, 0, 0, 0);
      `CHK({back_check_gen_en, undriven_pull_dir}, 2'b00)
      bus(1, TWI1_OFS, 32'h0000_0035, 0, 0);
      `CHK({sdaHoldNs, glitchMaxNs}, {6'd15, 7'd25})
      $display("t_reset done");
   endtask
   task t_fwd;
      bus(1, GEN1_OFS, 32'h0000_0074, 0, 0);
      st(1, 1, 0, 1);
      st(0, 1, 0, 0);
      bus(1, GEN1_OFS, 32'h0000_0078, 0, 0);
      st(0, 1, 1, 0);
      repeat (10) @(negedge sys_clk);
      `CHK(twiBusy, 1'b0)
      st(0, 0, 0, 0);
      bus(1, TWI1_OFS, 32'h0000_009E, 0, 0);
      st(0, 0, 1, 0);
      $display("t_fwd done");
   endtask
   task t_gate;
      repeat (6) @(negedge sys_clk);
      `CHK(colourOut, 24'hAB_CDEF)
      @(posedge sys_clk) partnerProtected <= 1;
      repeat (4) @(negedge sys_clk);
      `CHK(colourOut, 24'h00_0000)
      @(posedge sys_clk) partnerProtected <= 0;
      bus(1, GEN1_OFS, 32'h0000_007A, 0, 0);
      repeat (4) @(negedge sys_clk);
      `CHK(colourOut, 24'h00_0000)
      @(posedge sys_clk) pixel_valid <= 1;
      @(posedge sys_clk) pixel_valid <= 0;
      repeat (4) @(negedge sys_clk) `CHK(pixelValidOut, 1'b0)
      @(posedge sys_clk) pixel_valid <= 1;
      repeat (6) @(negedge sys_clk);
      `CHK({pixelValidOut, colourOut}, {1'b1, 24'hAB_CDEF})
      $display("t_gate done");
   endtask
   task t_dual;
      @(posedge sys_clk) dualLink <= 1;
      @(posedge sys_clk) line_sync <= 1;
      repeat (3) @(posedge sys_clk);
      line_sync <= 0;
      repeat (4) @(negedge sys_clk) `CHK(lineSyncOut, 1'b0)
      @(posedge sys_clk) line_sync <= 1;
      repeat (6) @(negedge sys_clk);
      `CHK(lineSyncOut, 1'b1)
      @(posedge sys_clk) begin line_sync <= 0; dualLink <= 0; end
      $display("t_dual done");
   endtask
   task t_wdog;
      bus(1, WDOG_OFS, 32'h0000_0006, 0, 0);
      bus(1, IRQ_MASK_OFS, 32'h0000_0001, 0, 0);
      stall <= 1;
      st(0, 1, 1, 0);
      wab();
      `CHK(n >= 29 && n <= 31, 1'b1)
      @(negedge sys_clk) `CHK({irq, twiBusy}, 2'b10)
      bus(1, IRQ_STAT_OFS, 32'h0000_0001, 0, 0);
      `CHK(irq, 1'b0)
      bus(1, WDOG_OFS, 32'h0000_0007, 0, 0);
      st(0, 1, 1, 0);
      wab();
      `CHK(n, 100)
      $display("t_wdog done");
   endtask
   task end_of_test();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      sys_rst <= 0;
      t_reset();
      t_fwd();
      t_gate();
      t_dual();
      t_wdog();
      end_of_test();
   end
endmodule
